// >>> rtl/gcs_consts.vh
`ifndef GCS_CONSTS_VH
`define GCS_CONSTS_VH

// clock rate, idle-bus timing and calibration lengths
`define GCS_CLK_HZ 40000000
`define GCS_IDLE_CC_SEC 5
`define GCS_IDLE_BOARD_SEC 20
`define GCS_AUTO_CAL_SEC 16
`define GCS_SHORT_CAL_CYC 256
// idle times are "more than", so one cycle past the figure
`define GCS_IDLE_CC_CYC (`GCS_IDLE_CC_SEC * `GCS_CLK_HZ + 1)
`define GCS_IDLE_BOARD_CYC (`GCS_IDLE_BOARD_SEC * `GCS_CLK_HZ + 1)
`define GCS_AUTO_CAL_CYC (`GCS_AUTO_CAL_SEC * `GCS_CLK_HZ)

// security keys and defaults
`define GCS_UNSEAL_CODE_RST 32'h36720414
`define GCS_FULL_CODE_RST 32'hffffffff
`define GCS_RESTORE_KEY_RST 32'h0def0fac
`define GCS_DEADBAND_RST 16'h0005

// security modes
`define GCS_MODE_SEALED 2'h0
`define GCS_MODE_UNSEALED 2'h1
`define GCS_MODE_FULL 2'h2

// gain factors are unsigned Q4.12, 1.0 at reset
`define GCS_GAIN_FRAC 12
`define GCS_GAIN_RST 16'h1000

`endif

// >>> rtl/gcs_sync.v
`timescale 1ns/1ps
module gcs_sync
(
	input wire clk,
	input wire rst,
	input wire d,
	output wire q
);
	reg s1_r;
	reg s2_r;

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
		end
		else
		begin
			s1_r <= d;
			s2_r <= s1_r;
		end
	end

	assign q = s2_r;
endmodule // gcs_sync

// >>> rtl/gcs_scale.v
`timescale 1ns/1ps
`include "gcs_consts.vh"
// signed value times unsigned Q4.12 gain, rounded toward minus infinity
module gcs_scale
(
	input wire signed [15:0] val,
	input wire [15:0] gain,
	output wire signed [15:0] res
);
	wire signed [32:0] prod;

	assign prod = val * $signed({1'b0, gain});
	assign res = prod[`GCS_GAIN_FRAC+15:`GCS_GAIN_FRAC];
endmodule // gcs_scale

// >>> rtl/gcs_top.v
`timescale 1ns/1ps
`include "gcs_consts.vh"
// Summary of operation
// - Average current is scaled by the current gain factor and reported in mA.
// - Accumulated charge is scaled by the charge gain factor on a time base, giving mAh.
// - Every counter offset calibration shorts the two sense inputs together while it runs.
// - An auto counter calibration starts when both bus lines sit low over 5 s at low current.
// - The auto counter calibration runs about 16 s, longer than the short commanded one.
// - The first time both bus lines are low over 20 s, the board offset is auto calibrated.
// - A per-unit board offset trim is subtracted apart from the counter offset trim.
// - Internal sensor temperature is corrected by its offset trim only, no gain.
// - Thermistor temperature is corrected by the external offset trim only, no gain.
// - The voltage offset trim is added to the cell voltage and set only by voltage calibration.
// - Average current inside the deadband, 5 mA by default, is reported as zero.
// - Sealed goes to unsealed only on the stored unseal code, default 0x36720414.
// - Unsealed goes to full access only on the stored full-access code, default 0xffffffff.
// - While sealed, the factory restore key pulses factory_restore for one cycle; no learned value is reset here.
module gcs_top
#(
	parameter [31:0] IDLE_CC_CYC = `GCS_IDLE_CC_CYC,
	parameter [31:0] IDLE_BOARD_CYC = `GCS_IDLE_BOARD_CYC,
	parameter [31:0] AUTO_CAL_CYC = `GCS_AUTO_CAL_CYC,
	parameter [31:0] SHORT_CAL_CYC = `GCS_SHORT_CAL_CYC
)
(
	input wire clk,
	input wire rst,
	input wire scl_in,
	input wire sda_in,
	input wire signed [15:0] cc_raw,
	input wire cc_raw_valid,
	input wire signed [15:0] temp_int_raw,
	input wire signed [15:0] temp_ext_raw,
	input wire temp_src_ext,
	input wire signed [15:0] volt_raw,
	input wire [15:0] sleep_current,
	input wire cal_mode,
	input wire cal_wr,
	input wire [2:0] cal_sel,
	input wire [15:0] cal_data,
	input wire cc_cal_start,
	input wire key_valid,
	input wire [31:0] key_data,
	input wire code_wr,
	input wire [1:0] code_sel,
	output reg signed [15:0] avg_current,
	output reg signed [31:0] charge_acc,
	output reg signed [15:0] temperature,
	output reg signed [15:0] cell_voltage,
	output reg [1:0] sec_mode,
	output reg factory_restore,
	output wire sense_short,
	output wire cal_busy,
	output reg board_cal_done,
	output reg [15:0] counter_offset_trim
);
	localparam ST_IDLE = 2'h0;
	localparam ST_AUTO = 2'h1;
	localparam ST_BOARD = 2'h2;
	localparam ST_SHORT = 2'h3;

	// bit 0 is the clock line, bit 1 the data line; both pins are asynchronous to clk
	wire [1:0] bus_pin = {sda_in, scl_in};
	wire [1:0] bus_s;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1)
		begin : g_bus_sync
			gcs_sync u_sync
			(
				.clk(clk),
				.rst(rst),
				.d(bus_pin[gi]),
				.q(bus_s[gi])
			);
		end
	endgenerate
	wire scl_s = bus_s[0];
	wire sda_s = bus_s[1];

	reg [15:0] current_gain_factor;
	reg [15:0] charge_gain_factor;
	reg signed [15:0] board_offset_r;
	reg signed [15:0] int_temp_off_r;
	reg signed [15:0] ext_temp_off_r;
	reg signed [15:0] volt_off_r;
	reg [15:0] deadband_r;
	reg [31:0] unseal_code;
	reg [31:0] full_access_code;
	reg [31:0] factory_restore_key;

	reg [1:0] state_r;
	reg [31:0] idle_cnt_r;
	reg [31:0] cal_cnt_r;
	reg signed [39:0] cal_acc_r;

	wire bus_idle = ~scl_s & ~sda_s;
	wire signed [15:0] cc_corr = cc_raw - $signed(counter_offset_trim) - board_offset_r;
	wire signed [15:0] cur_scaled;
	wire signed [15:0] chg_scaled;
	wire [15:0] cur_mag = cur_scaled[15] ? (~cur_scaled + 16'h0001) : cur_scaled;
	wire signed [15:0] avg_mag = avg_current[15] ? -avg_current : avg_current;
	// the board pass wins over the counter pass when both are due in the same cycle; at low current the counter pass is due first
	wire board_due = !cal_mode && bus_idle && !board_cal_done &&
		(idle_cnt_r >= IDLE_BOARD_CYC);
	wire cc_due = !cal_mode && bus_idle && (idle_cnt_r >= IDLE_CC_CYC) &&
		($signed({1'b0, avg_mag}) < $signed({1'b0, sleep_current}));

	// the ratio between the two gain factors carries the time base, so one multiplier shape
	gcs_scale u_cur (.val(cc_corr), .gain(current_gain_factor), .res(cur_scaled));
	gcs_scale u_chg (.val(cc_corr), .gain(charge_gain_factor), .res(chg_scaled));

	// the board pass leaves the sense inputs open: it must see the external offsets
	assign sense_short = (state_r == ST_AUTO) || (state_r == ST_SHORT);
	assign cal_busy = (state_r != ST_IDLE);

	// averaging divides by a power of two so no divider is needed
	wire signed [15:0] cal_mean_auto = cal_acc_r[39:24];
	// fixed at 256 samples: a shorter SHORT_CAL_CYC gives a mean scaled down with it
	wire signed [15:0] cal_mean_short = cal_acc_r[23:8];

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			avg_current <= 16'sh0000;
			charge_acc <= 32'sh00000000;
			temperature <= 16'sh0000;
			cell_voltage <= 16'sh0000;
		end
		else
		begin
			if (cc_raw_valid && !sense_short)
			begin
				if (cur_mag <= deadband_r)
					avg_current <= 16'sh0000;
				else
					avg_current <= cur_scaled;
				charge_acc <= charge_acc + {{16{chg_scaled[15]}}, chg_scaled};
			end
			if (temp_src_ext)
				temperature <= temp_ext_raw + ext_temp_off_r;
			else
				temperature <= temp_int_raw + int_temp_off_r;
			cell_voltage <= volt_raw + volt_off_r;
		end
	end

	// idle-bus timer; it saturates so a long parked bus never wraps into a fresh count
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			idle_cnt_r <= 32'h00000000;
		else if (!bus_idle)
			idle_cnt_r <= 32'h00000000;
		else if (idle_cnt_r != 32'hffffffff)
			idle_cnt_r <= idle_cnt_r + 32'h00000001;
	end

	// calibration sequencer
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_r <= ST_IDLE;
			cal_cnt_r <= 32'h00000000;
			cal_acc_r <= 40'sh0000000000;
			counter_offset_trim <= 16'h0000;
			board_offset_r <= 16'sh0000;
			board_cal_done <= 1'b0;
		end
		else
		begin
			if (cal_mode && cal_wr && cal_sel == 3'h2)
				board_offset_r <= $signed(cal_data);
			case (state_r)
				ST_IDLE:
				begin
					cal_acc_r <= 40'sh0000000000;
					cal_cnt_r <= 32'h00000000;
					if (cal_mode && cc_cal_start)
						state_r <= ST_SHORT;
					else if (board_due)
						state_r <= ST_BOARD;
					else if (cc_due)
						state_r <= ST_AUTO;
				end
				ST_AUTO, ST_BOARD:
				begin
					if (!bus_idle)
						state_r <= ST_IDLE;
					else
					begin
						if (cc_raw_valid)
							cal_acc_r <= cal_acc_r + {{24{cc_raw[15]}}, cc_raw};
						cal_cnt_r <= cal_cnt_r + 32'h00000001;
						if (cal_cnt_r == AUTO_CAL_CYC - 32'h00000001)
						begin
							state_r <= ST_IDLE;
							if (state_r == ST_AUTO)
								counter_offset_trim <= cal_mean_auto;
							else
							begin
								// board pass sees the real sense path, minus the chip offset
								board_offset_r <= cal_mean_auto - $signed(counter_offset_trim);
								board_cal_done <= 1'b1;
							end
						end
					end
				end
				ST_SHORT:
				begin
					if (cc_raw_valid)
						cal_acc_r <= cal_acc_r + {{24{cc_raw[15]}}, cc_raw};
					cal_cnt_r <= cal_cnt_r + 32'h00000001;
					if (cal_cnt_r == SHORT_CAL_CYC - 32'h00000001)
					begin
						state_r <= ST_IDLE;
						counter_offset_trim <= cal_mean_short;
					end
				end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// trims, reached only through calibration mode commands
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			current_gain_factor <= `GCS_GAIN_RST;
			charge_gain_factor <= `GCS_GAIN_RST;
			int_temp_off_r <= 16'sh0000;
			ext_temp_off_r <= 16'sh0000;
			volt_off_r <= 16'sh0000;
			deadband_r <= `GCS_DEADBAND_RST;
		end
		else if (cal_mode && cal_wr)
		begin
			case (cal_sel)
				3'h0: current_gain_factor <= cal_data;
				3'h1: charge_gain_factor <= cal_data;
				3'h3: int_temp_off_r <= $signed(cal_data);
				3'h4: ext_temp_off_r <= $signed(cal_data);
				3'h5: volt_off_r <= $signed(cal_data);
				3'h6: deadband_r <= cal_data;
				default: ;
			endcase
		end
	end

	// security modes and stored keys
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sec_mode <= `GCS_MODE_SEALED;
			factory_restore <= 1'b0;
			unseal_code <= `GCS_UNSEAL_CODE_RST;
			full_access_code <= `GCS_FULL_CODE_RST;
			factory_restore_key <= `GCS_RESTORE_KEY_RST;
		end
		else
		begin
			factory_restore <= 1'b0;
			if (key_valid)
			begin
				case (sec_mode)
					`GCS_MODE_SEALED:
					begin
						if (key_data == unseal_code)
							sec_mode <= `GCS_MODE_UNSEALED;
						else if (key_data == factory_restore_key)
							factory_restore <= 1'b1;
					end
					`GCS_MODE_UNSEALED:
					begin
						if (key_data == full_access_code)
							sec_mode <= `GCS_MODE_FULL;
					end
					default: ;
				endcase
			end
			// keys may only be rewritten with full access
			if (code_wr && sec_mode == `GCS_MODE_FULL)
			begin
				case (code_sel)
					2'h0: unseal_code <= key_data;
					2'h1: full_access_code <= key_data;
					2'h2: factory_restore_key <= key_data;
					default: ;
				endcase
			end
		end
	end
endmodule // gcs_top

// >>> verification/gcs_chk.sv
`timescale 1ns/1ps
`include "gcs_consts.vh"
module gcs_chk
(
	input wire clk,
	input wire rst,
	input wire scl_in,
	input wire cal_mode,
	input wire cal_wr,
	input wire signed [15:0] temp_int_raw,
	input wire temp_src_ext,
	input wire signed [15:0] volt_raw,
	input wire key_valid,
	input wire [31:0] key_data,
	input wire signed [15:0] temperature,
	input wire signed [15:0] cell_voltage,
	input wire [1:0] sec_mode,
	input wire factory_restore,
	input wire sense_short,
	input wire cal_busy,
	input wire board_cal_done
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	chk_unseal_key: assert property (sec_mode == `GCS_MODE_SEALED && key_valid &&
		key_data == `GCS_UNSEAL_CODE_RST |=> sec_mode == `GCS_MODE_UNSEALED) else $error("no unseal");
	chk_full_key: assert property (sec_mode == `GCS_MODE_UNSEALED && key_valid &&
		key_data == `GCS_FULL_CODE_RST |=> sec_mode == `GCS_MODE_FULL) else $error("no full");
	chk_bad_key: assert property (sec_mode == `GCS_MODE_SEALED && key_valid &&
		key_data != `GCS_UNSEAL_CODE_RST && key_data != `GCS_RESTORE_KEY_RST
		|=> sec_mode == `GCS_MODE_SEALED && !factory_restore) else $error("bad key took effect");
	chk_restore_key: assert property (sec_mode == `GCS_MODE_SEALED && key_valid &&
		key_data == `GCS_RESTORE_KEY_RST |=> factory_restore && sec_mode == `GCS_MODE_SEALED)
		else $error("no restore");
	chk_restore_cause: assert property (factory_restore |->
		$past(sec_mode) == `GCS_MODE_SEALED && $past(key_valid)) else $error("stray restore");
	chk_full_stays: assert property (sec_mode == `GCS_MODE_FULL |=>
		sec_mode == `GCS_MODE_FULL) else $error("left full");
	chk_short_busy: assert property (sense_short |-> cal_busy) else $error("short idle");
	chk_board_sticky: assert property (board_cal_done |=> board_cal_done)
		else $error("board done lost");
	chk_bus_abort: assert property (scl_in && !cal_mode |-> ##[1:4] !sense_short)
		else $error("no abort");
	chk_temp_hold: assert property ((!cal_wr && !temp_src_ext)[*4] |=>
		temperature - $past(temp_int_raw) == $past(temperature) - $past(temp_int_raw, 2))
		else $error("temp offset moved");
	chk_volt_hold: assert property ((!cal_wr)[*4] |=>
		cell_voltage - $past(volt_raw) == $past(cell_voltage) - $past(volt_raw, 2))
		else $error("volt offset moved");
endmodule // gcs_chk
bind gcs_top gcs_chk i_chk (.clk, .rst, .scl_in, .cal_mode, .cal_wr, .temp_int_raw, .temp_src_ext,
	.volt_raw, .key_valid, .key_data, .temperature, .cell_voltage, .sec_mode, .factory_restore,
	.sense_short, .cal_busy, .board_cal_done);

// >>> verification/gcs_host_model.sv
`timescale 1ns/1ps
module gcs_host_model
(
	input wire clk,
	input wire park,
	output reg scl,
	output reg sda
);
	// starts released high so the gauge never sees a false idle bus
	initial
	begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// parked host holds both lines low; otherwise clock toggles with data high
	always @(posedge clk)
	begin
		scl <= park ? 1'b0 : ~scl;
		sda <= ~park;
	end
endmodule // gcs_host_model

// >>> verification/test_gcs_top.sv
`timescale 1ns/1ps
`include "gcs_consts.vh"
module test_gcs_top;
	reg clk, rst, park, raw_vld, src_ext, cal_mode, cal_wr, cal_start, key_vld, code_wr;
	reg signed [15:0] cc_raw, t_int, t_ext, v_raw;
	reg signed [31:0] c0;
	reg [15:0] sleep, cal_data, t0;
	reg [2:0] cal_sel;
	reg [1:0] code_sel;
	reg [31:0] key;
	wire scl, sda, restore, short, busy, bdone;
	wire signed [15:0] avg, temp, volt;
	wire signed [31:0] charge;
	wire [1:0] mode;
	wire [15:0] cc_trim;
	integer error_cnt, checks, cyc, i, n;
	// short counts keep the idle and calibration waits to a few hundred cycles
	gcs_top #(.IDLE_CC_CYC(50), .IDLE_BOARD_CYC(100), .AUTO_CAL_CYC(64), .SHORT_CAL_CYC(16)) i_dut
	(
		.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .cc_raw(cc_raw), .cc_raw_valid(raw_vld),
		.temp_int_raw(t_int), .temp_ext_raw(t_ext), .temp_src_ext(src_ext), .volt_raw(v_raw),
		.sleep_current(sleep), .cal_mode(cal_mode), .cal_wr(cal_wr), .cal_sel(cal_sel),
		.cal_data(cal_data), .cc_cal_start(cal_start), .key_valid(key_vld), .key_data(key),
		.code_wr(code_wr), .code_sel(code_sel), .avg_current(avg), .charge_acc(charge),
		.temperature(temp), .cell_voltage(volt), .sec_mode(mode), .factory_restore(restore),
		.sense_short(short), .cal_busy(busy), .board_cal_done(bdone), .counter_offset_trim(cc_trim)
	);
	gcs_host_model i_host (.clk(clk), .park(park), .scl(scl), .sda(sda));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task end_of_test;
		if (error_cnt == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks = checks + 1;
		if (seen !== exp)
		begin
			error_cnt = error_cnt + 1;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task cal(input [2:0] sel, input [15:0] data);
		@(negedge clk);
		cal_sel = sel;
		cal_data = data;
		cal_wr = 1'b1;
		@(negedge clk);
		cal_wr = 1'b0;
	endtask
	task key_in(input [31:0] k);
		@(negedge clk);
		key = k;
		key_vld = 1'b1;
		@(negedge clk);
		key_vld = 1'b0;
	endtask
	// one extra cycle so either update edge is settled before the compare
	task samp(input signed [15:0] raw);
		@(negedge clk);
		cc_raw = raw;
		raw_vld = 1'b1;
		@(negedge clk);
		raw_vld = 1'b0;
		@(negedge clk);
	endtask
	always @(posedge clk)
	begin
		cyc = cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt = error_cnt + 1;
			end_of_test;
		end
	end
	initial
	begin
		{rst, park, raw_vld, src_ext, cal_mode, cal_wr, cal_start, key_vld, code_wr} = 9'h100;
		{cc_raw, cal_data, cal_sel, code_sel, key, sleep, c0} = 0;
		t_int = 16'sd100;
		t_ext = -16'sd40;
		v_raw = 16'sd3700;
		error_cnt = 0;
		checks = 0;
		cyc = 0;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		chk("mode", mode, 0);
		@(negedge clk);
		key = 32'h12345678;
		code_wr = 1'b1;
		@(negedge clk);
		code_wr = 1'b0;
		key_in(32'h36720415);
		chk("mode", mode, 0);
		key_in(`GCS_RESTORE_KEY_RST);
		chk("restore", restore, 1);
		chk("mode", mode, 0);
		key_in(`GCS_UNSEAL_CODE_RST);
		chk("mode", mode, 1);
		key_in(`GCS_RESTORE_KEY_RST);
		chk("restore", restore, 0);
		key_in(32'h7fffffff);
		chk("mode", mode, 1);
		key_in(`GCS_FULL_CODE_RST);
		chk("mode", mode, 2);
		cal(3'h3, 16'h0007);
		repeat (2) @(negedge clk);
		chk("temp", temp, 100);
		cal_mode = 1'b1;
		cal(3'h3, 16'h0007);
		cal(3'h4, 16'hfffd);
		cal(3'h5, 16'h000a);
		repeat (2) @(negedge clk);
		chk("temp", temp, 107);
		chk("volt", volt, 3710);
		src_ext = 1'b1;
		repeat (2) @(negedge clk);
		chk("temp", temp, -43);
		src_ext = 1'b0;
		cal(3'h0, 16'h2000);
		samp(100);
		chk("avg", avg, 200);
		cal(3'h0, 16'h1000);
		for (i = -6; i <= 6; i = i + 1)
		begin
			samp(i);
			chk("avg", avg, (i > -6 && i < 6) ? 0 : i);
		end
		cal(3'h6, 16'h0008);
		samp(8);
		chk("avg", avg, 0);
		samp(-9);
		chk("avg", avg, -9);
		cal(3'h6, 16'h0005);
		cal(3'h2, 16'h000a);
		samp(100);
		chk("avg", avg, 90);
		cal(3'h2, 16'h0000);
		cal(3'h1, 16'h0000);
		c0 = charge;
		samp(100);
		chk("charge", charge, c0);
		cal(3'h1, 16'h1000);
		samp(100);
		chk("charge", charge, c0 + 100);
		samp(0);
		@(negedge clk);
		cal_start = 1'b1;
		@(negedge clk);
		cal_start = 1'b0;
		@(negedge clk);
		chk("short", short, 1);
		for (n = 0; n < 40 && short; n = n + 1) @(negedge clk);
		chk("short", short, 0);
		cal_mode = 1'b0;
		park = 1'b1;
		repeat (80) @(negedge clk);
		chk("short", short, 0);
		park = 1'b0;
		sleep = 16'd100;
		// negative samples make any trim update visible, even through the 2^24 mean
		cc_raw = -16'sd1;
		raw_vld = 1'b1;
		repeat (4) @(negedge clk);
		t0 = cc_trim;
		park = 1'b1;
		for (n = 0; n < 70 && !short; n = n + 1) @(negedge clk);
		chk("short", short, 1);
		repeat (10) @(negedge clk);
		park = 1'b0;
		for (n = 0; n < 8 && short; n = n + 1) @(negedge clk);
		chk("short", short, 0);
		chk("trim", cc_trim, t0);
		chk("board", bdone, 0);
		park = 1'b1;
		for (n = 0; n < 70 && !short; n = n + 1) @(negedge clk);
		for (n = 0; n < 100 && short; n = n + 1) @(negedge clk);
		chk("auto_len", n, 64);
		chk("trim", cc_trim, 16'hffff);
		for (n = 0; n < 600 && !bdone; n = n + 1) @(negedge clk);
		chk("board", bdone, 1);
		end_of_test;
	end
endmodule // test_gcs_top
